/* hw/sdc_map.svh */
/*
 Constants of the quad bank SDRAM link: geometry, commands' fields
 and timing counts. Assumes a 100 MHz core clock shared by both ends.
*/
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH
`define SDC_CLK_MHZ    100
`define SDC_BANK_W     2
`define SDC_ROW_W      12
`define SDC_COL_W      10
`define SDC_DQ_W       8
`define SDC_ROWS       4096
`define SDC_COLS_X4    2048
`define SDC_COLS_X8    1024
`define SDC_COLS_X16   512
`define SDC_ARRAY_BITS 134217728
`define SDC_UADDR_W    24
`define SDC_AP_BIT     10
`define SDC_MR_BL_MSB  2
`define SDC_MR_IL_BIT  3
`define SDC_BL_FULL    3'h7
`define SDC_FULL_LEN   11'h400
`define SDC_CTRL_BL_CODE 3'h2
`define SDC_CTRL_BL    4
`define SDC_RD_PIPE    3
`define SDC_FIFO_DEPTH 4
`define SDC_TRCD_NS    20
`define SDC_TRP_NS     20
`define SDC_TRC_NS     70
`define SDC_TMRD_NS    20
`define SDC_CYC(ns)    (((ns) * `SDC_CLK_MHZ + 999) / 1000)
`define SDC_TRCD_CYC   `SDC_CYC(`SDC_TRCD_NS)
`define SDC_TRP_CYC    `SDC_CYC(`SDC_TRP_NS)
`define SDC_TRC_CYC    `SDC_CYC(`SDC_TRC_NS)
`define SDC_TMRD_CYC   `SDC_CYC(`SDC_TMRD_NS)
`define SDC_REF_MS     16
`define SDC_REF_ROWS   4096
`define SDC_TREFI_NS   (`SDC_REF_MS * 1000000 / `SDC_REF_ROWS)
`define SDC_TREFI_CYC  (`SDC_TREFI_NS * `SDC_CLK_MHZ / 1000)
`define SDC_CL         2
`endif

/* hw/sdc_pkg.sv */
/*
 Types shared by both ends of the SDRAM link.
 Assumes sdc_map.svh is on the include path.
*/
`include "sdc_map.svh"
package sdc_pkg;
   // Bit 3 is chip select low; bits 2:0 are row, column and write strobes
   typedef enum logic [3:0] {
      SDC_CMD_MRS = 4'h0,
      SDC_CMD_REF = 4'h1,
      SDC_CMD_PRE = 4'h2,
      SDC_CMD_ACT = 4'h3,
      SDC_CMD_WR  = 4'h4,
      SDC_CMD_RD  = 4'h5,
      SDC_CMD_BST = 4'h6,
      SDC_CMD_NOP = 4'h7,
      SDC_CMD_INH = 4'hF
   } sdc_cmd_t;
   typedef logic [`SDC_DQ_W-1:0]    sdc_data_t;
   typedef logic [`SDC_UADDR_W-1:0] sdc_uaddr_t;
endpackage

/* hw/sdc_if.sv */
/*
 Pin bundle between the memory controller and the SDRAM device.
 Assumes both ends run on the same clock; resolves the shared data bus.
*/
`timescale 1ns/1ps
`include "sdc_map.svh"
interface sdc_if;
   logic                  cs_n;
   logic                  ras_n;
   logic                  cas_n;
   logic                  we_n;
   logic                  cke;
   logic                  dqm;
   logic [`SDC_BANK_W-1:0] ba;
   logic [`SDC_ROW_W-1:0]  addr;
   logic [`SDC_DQ_W-1:0]   c_dq;
   logic                  c_dq_oe;
   logic [`SDC_DQ_W-1:0]   m_dq;
   logic                  m_dq_oe;
   logic [`SDC_DQ_W-1:0]   dq;
   // Undriven bus reads as zero
   assign dq = c_dq_oe ? c_dq : (m_dq_oe ? m_dq : '0);
   modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, dqm, ba, addr,
                 output c_dq, c_dq_oe, input dq);
   modport mem  (input cs_n, ras_n, cas_n, we_n, cke, dqm, ba, addr,
                 input dq, output m_dq, m_dq_oe);
endinterface

/* hw/sdc_mem_end.sv */
/*
 Device end of the SDRAM link: four banks, burst engine, mode,
 refresh and power-down handling, x8 organisation.
 Assumes the controller keeps row-to-column and precharge timing.
*/
// What this block does
// - Bank: 4096 rows, 1024 columns of 8 bits
// - Four banks storing 134,217,728 bits total
// - All inputs sampled on rising clock edge
// - Controller activates a row before read/write
// - Activate takes bank select and row address
// - Read/write address gives burst start column
// - Burst runs programmed length and order unaided
// - Burst lengths 1, 2, 4, 8, full page
// - Burst terminate ends a running burst
// - Auto precharge closes row at burst end
// - New column address accepted every cycle
// - One bank precharges while another works
// - Following burst columns generated internally
// - Auto refresh and power-down on command
// - Hot option: refresh whole array each 16ms
// - Hot option: controller never uses self refresh
// - Chip select high ignores commands, bursts continue
// - Read/write address bit 10 requests precharge
// - Precharge bit 10 high means all banks
// - Data mask blocks writes, floats reads after two
`timescale 1ns/1ps
`include "sdc_map.svh"
module sdc_mem_end (
   input  wire logic                   i_core_clk,
   input  wire logic                   i_rst,
   sdc_if.mem                          bus,
   output logic                        o_powered_down,
   output logic                        o_burst_active,
   output logic [3:0]                  o_open_banks,
   output logic [`SDC_ROW_W-1:0]       o_refresh_count
);
   import sdc_pkg::*;

   localparam int DEPTH = `SDC_ARRAY_BITS / `SDC_DQ_W;

   // Full array; rows alias nothing, index is bank, row, column
   sdc_data_t              mem [0:DEPTH-1];
   logic [3:0]             bank_open;
   logic [`SDC_ROW_W-1:0]  open_row [0:3];
   logic [2:0]             mr_bl;
   logic                   mr_il;
   logic                   burst_on;
   logic                   burst_wr;
   logic                   burst_ap;
   logic [`SDC_BANK_W-1:0] b_bank;
   logic [`SDC_COL_W-1:0]  b_start;
   logic [10:0]            b_idx;
   logic                   pwr_down;
   logic [`SDC_ROW_W-1:0]  ref_row;
   logic                   rd1_v;
   sdc_data_t              rd1_d;
   logic                   dqm1;
   logic                   rd2_v;
   sdc_data_t              rd2_d;

   function automatic logic [10:0] blen(input logic [2:0] bl);
      case (bl)
         3'h0:         blen = 11'h001;
         3'h1:         blen = 11'h002;
         3'h2:         blen = 11'h004;
         3'h3:         blen = 11'h008;
         `SDC_BL_FULL: blen = `SDC_FULL_LEN;
         default:      blen = 11'h001;
      endcase
   endfunction

   // Column of beat ix; wraps inside the burst-sized block
   function automatic logic [`SDC_COL_W-1:0] col_at(
      input logic [`SDC_COL_W-1:0] st,
      input logic [10:0]           ix,
      input logic [2:0]            bl,
      input logic                  il
   );
      logic [`SDC_COL_W-1:0] m;
      logic [`SDC_COL_W-1:0] off;
      m   = 10'(blen(bl) - 11'h001);
      off = (il && bl != `SDC_BL_FULL) ? (st ^ ix[9:0])
                                       : (st + ix[9:0]);
      col_at = (st & ~m) | (off & m);
   endfunction

   wire [3:0] code = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
   // Deselect and power-down mask the decoder only
   wire cmd_live = ~bus.cs_n & bus.cke & ~pwr_down;
   wire is_act = cmd_live && code == SDC_CMD_ACT;
   wire is_rd  = cmd_live && code == SDC_CMD_RD;
   wire is_wr  = cmd_live && code == SDC_CMD_WR;
   wire is_bst = cmd_live && code == SDC_CMD_BST;
   wire is_pre = cmd_live && code == SDC_CMD_PRE;
   wire is_ref = cmd_live && code == SDC_CMD_REF;
   wire is_mrs = cmd_live && code == SDC_CMD_MRS;
   wire new_rw = is_rd | is_wr;

   // A new read/write always wins over the running burst
   wire [10:0] cur_idx = new_rw ? 11'h000 : b_idx;
   wire [`SDC_COL_W-1:0] acc_col =
      new_rw ? bus.addr[`SDC_COL_W-1:0]
             : col_at(b_start, b_idx, mr_bl, mr_il);
   wire [`SDC_BANK_W-1:0] acc_bank = new_rw ? bus.ba : b_bank;
   wire acc_on  = new_rw | (burst_on & ~is_bst);
   wire acc_wr  = new_rw ? is_wr : burst_wr;
   wire acc_ap  = new_rw ? bus.addr[`SDC_AP_BIT] : burst_ap;
   wire beat_last = acc_on && mr_bl != `SDC_BL_FULL &&
                    cur_idx == blen(mr_bl) - 11'h001;
   wire ap_close  = beat_last & acc_ap;
   wire [`SDC_UADDR_W-1:0] acc_addr =
      {acc_bank, open_row[acc_bank], acc_col};
   wire wr_en = acc_on & acc_wr & ~bus.dqm;

   always_ff @(posedge i_core_clk) begin
      if (wr_en)
         mem[acc_addr] <= bus.dq;
      rd1_d <= mem[acc_addr];
      rd2_d <= rd1_d;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         burst_on <= 1'b0;
         burst_wr <= 1'b0;
         burst_ap <= 1'b0;
         b_bank   <= '0;
         b_start  <= '0;
         b_idx    <= '0;
      end else begin
         burst_on <= acc_on & ~beat_last;
         if (new_rw) begin
            burst_wr <= is_wr;
            burst_ap <= bus.addr[`SDC_AP_BIT];
            b_bank   <= bus.ba;
            b_start  <= bus.addr[`SDC_COL_W-1:0];
         end
         b_idx <= acc_on ? cur_idx + 11'h001 : 11'h000;
      end
   end

   // Each bank keeps its own state so banks overlap freely
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         bank_open <= '0;
         for (int i = 0; i < 4; i++)
            open_row[i] <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (is_act && bus.ba == 2'(i)) begin
               bank_open[i] <= 1'b1;
               open_row[i]  <= bus.addr;
            end else if (is_pre &&
                         (bus.addr[`SDC_AP_BIT] ||
                          bus.ba == 2'(i))) begin
               bank_open[i] <= 1'b0;
            end else if (ap_close && acc_bank == 2'(i)) begin
               bank_open[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         mr_bl    <= 3'h0;
         mr_il    <= 1'b0;
         pwr_down <= 1'b0;
         ref_row  <= '0;
      end else begin
         if (is_mrs && bank_open == 4'h0) begin
            mr_bl <= bus.addr[`SDC_MR_BL_MSB:0];
            mr_il <= bus.addr[`SDC_MR_IL_BIT];
         end
         // Refresh walks the rows; self refresh is not modelled
         if (is_ref && bank_open == 4'h0)
            ref_row <= ref_row + 1'b1;
         if (~bus.cke && ~burst_on)
            pwr_down <= 1'b1;
         else if (bus.cke)
            pwr_down <= 1'b0;
      end
   end

   // Two stage read pipe gives the column latency
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rd1_v <= 1'b0;
         dqm1  <= 1'b0;
         rd2_v <= 1'b0;
      end else begin
         rd1_v <= acc_on & ~acc_wr;
         dqm1  <= bus.dqm;
         rd2_v <= rd1_v & ~dqm1;
      end
   end

   assign bus.m_dq    = rd2_d;
   assign bus.m_dq_oe = rd2_v;
   assign o_powered_down  = pwr_down;
   assign o_burst_active  = burst_on;
   assign o_open_banks    = bank_open;
   assign o_refresh_count = ref_row;
endmodule // sdc_mem_end

/* hw/sdc_ctrl_end.sv */
/*
 Controller end of the SDRAM link plus its write data FIFO.
 Assumes a device end that keeps a two cycle column latency.
*/
`timescale 1ns/1ps
`include "sdc_map.svh"
module sdc_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input  wire logic                 i_core_clk,
   input  wire logic                 i_rst,
   input  wire logic                 i_in_valid,
   output logic                      o_in_ready,
   input  wire logic [W-1:0]         i_in_data,
   output logic                      o_out_valid,
   input  wire logic                 i_out_ready,
   output logic [W-1:0]              o_out_data,
   output logic [$clog2(D+1)-1:0]    o_count
);
   import sdc_pkg::*;
   localparam int PW = $clog2(D);
   logic [W-1:0]          data [0:D-1];
   logic [PW-1:0]         wp;
   logic [PW-1:0]         rp;
   logic [$clog2(D+1)-1:0] cnt;
   wire push = i_in_valid & o_in_ready;
   wire pop  = o_out_valid & i_out_ready;
   assign o_in_ready  = cnt != D[$clog2(D+1)-1:0];
   assign o_out_valid = cnt != '0;
   assign o_out_data  = data[rp];
   assign o_count     = cnt;
   always_ff @(posedge i_core_clk) begin
      if (push)
         data[wp] <= i_in_data;
   end
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         if (push)
            wp <= (wp == PW'(D - 1)) ? '0 : wp + 1'b1;
         if (pop)
            rp <= (rp == PW'(D - 1)) ? '0 : rp + 1'b1;
         cnt <= cnt + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
      end
   end
endmodule // sdc_fifo

module sdc_ctrl_end (
   input  wire logic            i_core_clk,
   input  wire logic            i_rst,
   sdc_if.ctrl                  bus,
   input  wire logic            i_req_valid,
   input  wire logic            i_req_write,
   input  wire sdc_pkg::sdc_uaddr_t i_req_addr,
   output logic                 o_req_ready,
   input  wire logic            i_wdata_valid,
   input  wire sdc_pkg::sdc_data_t  i_wdata,
   output logic                 o_wdata_ready,
   output logic                 o_rdata_valid,
   output sdc_pkg::sdc_data_t   o_rdata,
   output logic                 o_init_done
);
   import sdc_pkg::*;
   typedef enum {ST_INIT_PRE, ST_INIT_REF, ST_INIT_MRS, ST_IDLE,
                 ST_RW, ST_BURST, ST_WAIT} sdc_state_t;
   localparam logic [8:0] REFI = 9'(`SDC_TREFI_CYC);
   sdc_state_t          state;
   sdc_state_t          ret;
   sdc_cmd_t            cmd;
   logic [3:0]          timer;
   logic [1:0]          refs_left;
   logic [1:0]          beats;
   logic                wr_l;
   sdc_uaddr_t          addr_l;
   logic [8:0]          ref_cnt;
   logic                ref_due;
   logic [`SDC_RD_PIPE-1:0] rd_sh;
   sdc_data_t           f_data;
   logic [2:0]          f_count;
   logic                f_valid;

   wire in_burst = state == ST_RW || state == ST_BURST;
   wire f_pop = in_burst & wr_l;
   wire enough = f_count >= 3'(`SDC_CTRL_BL);
   wire ref_hit = ref_cnt == REFI - 9'h001;
   wire take_ref = state == ST_IDLE && ref_due;
   // Writes wait for a whole burst of data so beats never starve
   assign o_req_ready = state == ST_IDLE && !ref_due &&
                        (!i_req_write || enough);
   wire take_req = o_req_ready & i_req_valid;

   sdc_fifo #(.W(`SDC_DQ_W), .D(`SDC_FIFO_DEPTH)) u_wfifo (
      .i_core_clk  (i_core_clk),
      .i_rst       (i_rst),
      .i_in_valid  (i_wdata_valid),
      .o_in_ready  (o_wdata_ready),
      .i_in_data   (i_wdata),
      .o_out_valid (f_valid),
      .i_out_ready (f_pop),
      .o_out_data  (f_data),
      .o_count     (f_count)
   );

   // Periodic auto refresh; self refresh is never entered
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         ref_cnt <= '0;
         ref_due <= 1'b0;
      end else begin
         ref_cnt <= ref_hit ? 9'h000 : ref_cnt + 9'h001;
         ref_due <= ref_hit | (ref_due & ~take_ref);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state       <= ST_INIT_PRE;
         ret         <= ST_IDLE;
         cmd         <= SDC_CMD_INH;
         bus.ba      <= '0;
         bus.addr    <= '0;
         bus.c_dq    <= '0;
         bus.c_dq_oe <= 1'b0;
         timer       <= '0;
         refs_left   <= 2'h2;
         beats       <= '0;
         wr_l        <= 1'b0;
         addr_l      <= '0;
         o_init_done <= 1'b0;
      end else begin
         cmd         <= SDC_CMD_NOP;
         bus.c_dq_oe <= f_pop;
         bus.c_dq    <= f_data;
         case (state)
            ST_INIT_PRE: begin
               cmd <= SDC_CMD_PRE;
               bus.addr[`SDC_AP_BIT] <= 1'b1;
               timer <= 4'(`SDC_TRP_CYC);
               ret   <= ST_INIT_REF;
               state <= ST_WAIT;
            end
            ST_INIT_REF: begin
               cmd <= SDC_CMD_REF;
               refs_left <= refs_left - 2'h1;
               timer <= 4'(`SDC_TRC_CYC);
               ret   <= refs_left == 2'h1 ? ST_INIT_MRS : ST_INIT_REF;
               state <= ST_WAIT;
            end
            ST_INIT_MRS: begin
               cmd <= SDC_CMD_MRS;
               bus.addr <= {9'h000, `SDC_CTRL_BL_CODE};
               timer <= 4'(`SDC_TMRD_CYC);
               ret   <= ST_IDLE;
               state <= ST_WAIT;
               o_init_done <= 1'b1;
            end
            ST_IDLE: begin
               if (take_ref) begin
                  cmd   <= SDC_CMD_REF;
                  timer <= 4'(`SDC_TRC_CYC);
                  ret   <= ST_IDLE;
                  state <= ST_WAIT;
               end else if (take_req) begin
                  cmd      <= SDC_CMD_ACT;
                  bus.ba   <= i_req_addr[23:22];
                  bus.addr <= i_req_addr[21:10];
                  addr_l   <= i_req_addr;
                  wr_l     <= i_req_write;
                  timer    <= 4'(`SDC_TRCD_CYC);
                  ret      <= ST_RW;
                  state    <= ST_WAIT;
               end
            end
            ST_RW: begin
               // Auto precharge saves a command per access
               cmd <= wr_l ? SDC_CMD_WR : SDC_CMD_RD;
               bus.addr <= {1'b0, 1'b1, addr_l[9:0]};
               beats <= 2'(`SDC_CTRL_BL - 1);
               state <= ST_BURST;
            end
            ST_BURST: begin
               beats <= beats - 2'h1;
               if (beats == 2'h1) begin
                  timer <= 4'(`SDC_TRP_CYC + `SDC_CL);
                  ret   <= ST_IDLE;
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               timer <= timer - 4'h1;
               if (timer <= 4'h1)
                  state <= ret;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rd_sh         <= '0;
         o_rdata_valid <= 1'b0;
         o_rdata       <= '0;
      end else begin
         rd_sh         <= {rd_sh[`SDC_RD_PIPE-2:0], in_burst & ~wr_l};
         o_rdata_valid <= rd_sh[`SDC_RD_PIPE-1];
         if (rd_sh[`SDC_RD_PIPE-1])
            o_rdata <= bus.dq;
      end
   end

   assign bus.cs_n  = cmd[3];
   assign bus.ras_n = cmd[2];
   assign bus.cas_n = cmd[1];
   assign bus.we_n  = cmd[0];
   assign bus.cke   = 1'b1;
   assign bus.dqm   = 1'b0;
endmodule // sdc_ctrl_end

/* tb/sdc_link_props.sv */
/*
 Assertions on the pins between controller end and device end.
 Assumes one clock for both ends and a controller that never masks data.
*/
`timescale 1ns/1ps
module sdc_link_props (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   input  wire logic        cke,
   input  wire logic        dqm,
   input  wire logic [1:0]  ba,
   input  wire logic [11:0] addr,
   input  wire logic        c_dq_oe,
   input  wire logic        m_dq_oe
);
   import sdc_pkg::*;
   wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
   wire       rd  = cke && cmd == SDC_CMD_RD;
   wire       wr  = cke && cmd == SDC_CMD_WR;
   wire       act = cke && cmd == SDC_CMD_ACT;
   wire       rf  = cke && cmd == SDC_CMD_REF;
   // Saturates so a long idle spell cannot wrap into a false pass
   logic [9:0] gap;
   always_ff @(posedge i_core_clk) begin
      if (i_rst || rf) begin
         gap <= 10'h000;
      end else if (gap != 10'h3FF) begin
         gap <= gap + 10'h001;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   a_read_oe_burst: assert property (rd && !dqm |-> ##2 m_dq_oe [*4])
      else $error("read burst not driven for four beats");
   a_burst_len_four: assert property (rd |-> ##6 !m_dq_oe)
      else $error("read burst longer than four beats");
   a_oe_from_read: assert property (m_dq_oe |-> $past(rd, 2) ||
      $past(rd, 3) || $past(rd, 4) || $past(rd, 5))
      else $error("device drives data outside a read burst");
   a_act_before_col: assert property ((rd || wr) |->
      $past(act, 3) && $past(ba, 3) == ba)
      else $error("column command without activate three cycles before");
   a_write_drive: assert property (wr |-> c_dq_oe [*4] ##1 !c_dq_oe)
      else $error("write data not driven for four beats");
   a_auto_pre_req: assert property ((rd || wr) |-> addr[10])
      else $error("column command without auto precharge");
   a_ref_spacing: assert property (rf |=> (!act && !rf) [*6])
      else $error("command too soon after refresh");
   a_refresh_gap: assert property (gap < 10'h1A4)
      else $error("refresh interval exceeded");
   a_cke_held: assert property (cke)
      else $error("clock enable dropped");
   c_read: cover property (rd);
   c_write: cover property (wr);
   c_refresh: cover property (rf);
endmodule // sdc_link_props

/* tb/quad_bank_sdram_access_core_tb.sv */
/*
 Bench for both link ends, plus a second device end driven pin by pin.
 Assumes one 100 MHz clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
module quad_bank_sdram_access_core_tb;
   import sdc_pkg::*;
   localparam logic [3:0] modes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'hA};
   logic        i_core_clk, i_rst, req_valid, req_write, req_ready;
   logic        wdata_valid, wdata_ready, rdata_valid, init_done, pdown, bact;
   sdc_uaddr_t  req_addr, a;
   sdc_data_t   wdata, rdata, d [9];
   sdc_data_t   exp_q [$];
   logic [3:0]  open1, open2, md;
   logic [11:0] refc, c0, row;
   logic [9:0]  s;
   logic [1:0]  b;
   int          num_errors, checked, n;
   sdc_if link_if ();
   sdc_if probe_if ();
   sdc_ctrl_end u_sdc_ctrl_end (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .bus(link_if.ctrl), .i_req_valid(req_valid), .i_req_write(req_write),
      .i_req_addr(req_addr), .o_req_ready(req_ready),
      .i_wdata_valid(wdata_valid), .i_wdata(wdata),
      .o_wdata_ready(wdata_ready), .o_rdata_valid(rdata_valid),
      .o_rdata(rdata), .o_init_done(init_done));
   sdc_mem_end u_sdc_mem_end (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .bus(link_if.mem), .o_powered_down(), .o_burst_active(),
      .o_open_banks(open1), .o_refresh_count(refc));
   sdc_mem_end u_sdc_mem_end2 (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .bus(probe_if.mem), .o_powered_down(pdown), .o_burst_active(bact),
      .o_open_banks(open2), .o_refresh_count());
   sdc_link_props u_sdc_link_props (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .cs_n(link_if.cs_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n),
      .we_n(link_if.we_n), .cke(link_if.cke), .dqm(link_if.dqm),
      .ba(link_if.ba), .addr(link_if.addr), .c_dq_oe(link_if.c_dq_oe),
      .m_dq_oe(link_if.m_dq_oe));
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   task automatic finish_test();
      if (num_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [9:0] col_of(input logic [3:0] mo,
                                         input logic [9:0] st, input int i);
      logic [9:0] m;
      m = (mo[2:0] == 3'h7) ? 10'h3FF : 10'((1 << mo[1:0]) - 1);
      if (mo[3]) begin
         return (st & ~m) | ((st ^ 10'(i)) & m);
      end
      return (st & ~m) | ((st + 10'(i)) & m);
   endfunction
   // Second device end: command changes just after an edge, held one cycle
   task automatic pc(input logic [3:0] c, input logic [11:0] ad);
      @(posedge i_core_clk);
      {probe_if.cs_n, probe_if.ras_n, probe_if.cas_n, probe_if.we_n} <= c;
      probe_if.addr <= ad;
      probe_if.ba   <= b;
   endtask
   task automatic idle(input int k);
      repeat (k) pc(4'h7, 12'h000);
   endtask
   task automatic push(input int k);
      @(posedge i_core_clk);
      wdata_valid <= 1'b1;
      wdata       <= sdc_data_t'($urandom);
      repeat (k) begin
         @(posedge i_core_clk);
         if (wdata_ready === 1'b1) begin
            exp_q.push_back(wdata);
            wdata <= sdc_data_t'($urandom);
         end
      end
      wdata_valid <= 1'b0;
   endtask
   task automatic req(input logic w);
      int t;
      @(posedge i_core_clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr  <= a;
      t = 0;
      do begin
         @(posedge i_core_clk);
         t++;
      end while (req_ready !== 1'b1 && t < 900);
      req_valid <= 1'b0;
      // A request that is never taken counts as a mismatch
      if (t >= 900) num_errors++;
      n = 0;
      while (!w && n < 4 && t < 900) begin
         @(posedge i_core_clk);
         t++;
         if (rdata_valid === 1'b1) begin
            chk({4'h0, rdata}, {4'h0, exp_q[n]});
            n++;
         end
      end
      if (!w) chk(12'(n), 12'h004);
   endtask
   initial begin
      repeat (20000) @(posedge i_core_clk);
      num_errors++;
      finish_test();
   end
   initial begin
      i_rst = 1'b1;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = '0;
      wdata_valid = 1'b0;
      wdata = '0;
      b = 2'h0;
      {probe_if.cs_n, probe_if.ras_n, probe_if.cas_n, probe_if.we_n} = 4'hF;
      probe_if.cke = 1'b1;
      probe_if.dqm = 1'b0;
      probe_if.c_dq_oe = 1'b0;
      probe_if.c_dq = '0;
      probe_if.ba = '0;
      probe_if.addr = '0;
      void'($urandom(32'hF561));
      repeat (2) @(posedge i_core_clk);
      i_rst <= 1'b0;
      n = 0;
      while (init_done !== 1'b1 && n < 100) begin
         @(posedge i_core_clk);
         n++;
      end
      repeat (2) @(posedge i_core_clk);
      chk({11'h000, init_done}, 12'h001);
      chk(refc, 12'h002);
      push(8);
      chk(12'(exp_q.size()), 12'h004);
      for (int i = 0; i < 8; i++) begin
         a = sdc_uaddr_t'($urandom);
         if (i == 0) a = 24'hFFFFFF;
         if (i == 1) a = 24'h000003;
         if (i > 0) push(4);
         req(1'b1);
         req(1'b0);
         chk({8'h00, open1}, 12'h000);
         exp_q.delete();
      end
      c0 = refc;
      repeat (1000) @(posedge i_core_clk);
      chk({11'h000, refc - c0 >= 12'h002}, 12'h001);
      // Each burst length, plus interleaved length four: write at a random start, read back one column a cycle
      for (int k = 0; k < 6; k++) begin
         md = modes[k];
         b = 2'($urandom);
         row = 12'($urandom);
         s = 10'($urandom);
         n = (md[2:0] == 3'h7) ? 6 : (1 << md[1:0]);
         pc(4'h2, 12'h400);
         pc(4'h0, {8'h00, md});
         pc(4'h3, row);
         for (int i = 0; i <= n; i++) begin
            d[i] = sdc_data_t'($urandom);
            pc(i == 0 ? 4'h4 : (i < n ? 4'hC : 4'h6),
               i == 0 ? {2'h0, s} : 12'h000);
            probe_if.c_dq    <= d[i];
            probe_if.c_dq_oe <= (i < n);
         end
         idle(2);
         chk({11'h000, bact}, 12'h000);
         pc(4'h2, 12'h400);
         pc(4'h0, 12'h000);
         pc(4'h3, row);
         for (int i = 0; i < n + 3; i++) begin
            pc(i < n ? 4'h5 : 4'h7, {2'h0, col_of(md, s, i)});
            if (i >= 3) chk({4'h0, probe_if.dq}, {4'h0, d[i - 3]});
         end
      end
      pc(4'h5, 12'h000);
      probe_if.dqm <= 1'b1;
      pc(4'h7, 12'h000);
      probe_if.dqm <= 1'b0;
      idle(2);
      chk({11'h000, probe_if.m_dq_oe}, 12'h000);
      pc(4'h2, 12'h400);
      b = 2'h0;
      pc(4'h3, row);
      b = 2'h2;
      pc(4'h3, row);
      b = 2'h0;
      pc(4'h2, 12'h000);
      idle(2);
      chk({8'h00, open2}, 12'h004);
      b = 2'h1;
      pc(4'h3, row);
      pc(4'h5, 12'h400);
      idle(2);
      chk({8'h00, open2}, 12'h004);
      pc(4'h2, 12'h400);
      pc(4'h7, 12'h000);
      probe_if.cke <= 1'b0;
      idle(3);
      chk({11'h000, pdown}, 12'h001);
      pc(4'h3, row);
      pc(4'h7, 12'h000);
      probe_if.cke <= 1'b1;
      idle(3);
      chk({7'h00, open2, pdown}, 12'h000);
      finish_test();
   end
endmodule // quad_bank_sdram_access_core_tb
